// ### hdl/video_sync_processor.sv
`timescale 1ns/1ps
`include "video_sync_params.svh"
// Operation
// - data clock rises midway between output data changes
// - first 23 data sets after start are flagged invalid
// - sampling phase set in 32 steps covering 360 degrees
// - input line sync polarity detected, output polarity known
// - line sync output polarity programmable high or low
// - line sync output aligned to data clock and pixel data
// - line sync output width equals programmed count of output data sets
// - coast blocks the pll reference so pixel clock free-runs
// - coast taken from separated vertical sync or external pin
// - slicer trigger level five bits, slicer gives composite sync
// - separator threshold N gives minimum pulse of N+1 ticks of about 167 ns
// - separator is 8-bit counter at 6 MHz, polarity independent
// - counter up in pulse, down after; over threshold means vsync
// - on vsync counter clears, counts after pulse, threshold ends it
// - separated vsync lags original by threshold duration
// - regenerator runs unconfigured, tolerates extra and missing pulses
// - filter window x times 25 ns each side of regenerated edge
// - filter passes only pulses inside window
// - status bit reports extraneous pulses on the sync input
// - select bit routes filtered sync to pll reference
// - select bit routes regenerated sync to sync processing
// - polarity setting of one means active high
// - vertical sync filter enable bit
module video_sync_processor #(
    parameter int LINE_W = 12
) (
    // clock and reset
    input  wire logic                      core_clk_in,
    input  wire logic                      nrst_in,
    // register port
    input  wire video_sync_pkg::reg_req_s  reg_req_in,
    output logic [7:0]                     reg_rdata_out,
    // sync pins and pixel data
    input  wire video_sync_pkg::sync_pins_s pins_in,
    input  wire logic [7:0]                pixel_in,
    // outputs
    output logic [7:0]                     pixel_out,
    output logic                           pixel_valid_out,
    output logic                           output_data_clock_out,
    output logic                           line_sync_out,
    output logic                           frame_sync_out,
    output logic                           pll_ref_out,
    output logic                           coast_out,
    output logic [4:0]                     phase_step_out,
    output logic [4:0]                     slicer_level_out,
    output logic                           vsync_filter_en_out
);
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    // window half width in core cycles, rounded down, never below one
    function automatic logic [LINE_W-1:0] win_cycles(input logic [7:0] x);
        logic [15:0] t;
        t = 16'((32'(x) * `VSP_WIN_UNIT_NS) / `VSP_CLK_NS);
        win_cycles = (t == 16'h0000) ? LINE_W'(1) : t[LINE_W-1:0];
    endfunction : win_cycles

    function automatic logic [7:0] sat_step(input logic [7:0] v, input logic up);
        if (up)
            sat_step = (v == 8'hff) ? v : v + 8'h01;
        else
            sat_step = (v == 8'h00) ? v : v - 8'h01;
    endfunction : sat_step

    // ------------------------------------------------
    // registers
    // ------------------------------------------------
    logic [7:0] phase_r, thr_r, coast_r, slicer_r, window_r, sel_r, width_r, opol_r;
    logic       extra_r;
    logic       extra_set;
    logic [7:0] rdata_nxt;
    logic       wr_any;

    assign wr_any = reg_req_in.wr;

    // read mux, unmapped offsets read zero
    always_comb begin
        case (reg_req_in.addr)
            `VSP_OFS_PHASE:     rdata_nxt = {3'h0, phase_r[4:0]};
            `VSP_OFS_SEP_THR:   rdata_nxt = thr_r;
            `VSP_OFS_COAST:     rdata_nxt = coast_r;
            `VSP_OFS_STATUS:    rdata_nxt = {7'h00, extra_r};
            `VSP_OFS_SLICER:    rdata_nxt = {slicer_r[7:3], 3'h0};
            `VSP_OFS_WINDOW:    rdata_nxt = window_r;
            `VSP_OFS_SYNC_SEL:  rdata_nxt = sel_r;
            `VSP_OFS_OUT_WIDTH: rdata_nxt = width_r;
            `VSP_OFS_OUT_POL:   rdata_nxt = opol_r;
            default:            rdata_nxt = 8'h00;
        endcase
    end

    // register writes and the read data stage
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            phase_r       <= `VSP_RST_PHASE;
            thr_r         <= `VSP_RST_SEP_THR;
            coast_r       <= `VSP_RST_COAST;
            slicer_r      <= `VSP_RST_SLICER;
            window_r      <= `VSP_RST_WINDOW;
            sel_r         <= `VSP_RST_SYNC_SEL;
            width_r       <= `VSP_RST_OUT_WIDTH;
            opol_r        <= `VSP_RST_OUT_POL;
            reg_rdata_out <= 8'h00;
        end else begin
            if (wr_any) begin
                case (reg_req_in.addr)
                    `VSP_OFS_PHASE:     phase_r  <= reg_req_in.wdata;
                    `VSP_OFS_SEP_THR:   thr_r    <= reg_req_in.wdata;
                    `VSP_OFS_COAST:     coast_r  <= reg_req_in.wdata;
                    `VSP_OFS_SLICER:    slicer_r <= reg_req_in.wdata;
                    `VSP_OFS_WINDOW:    window_r <= reg_req_in.wdata;
                    `VSP_OFS_SYNC_SEL:  sel_r    <= reg_req_in.wdata;
                    `VSP_OFS_OUT_WIDTH: width_r  <= reg_req_in.wdata;
                    `VSP_OFS_OUT_POL:   opol_r   <= reg_req_in.wdata;
                    default:            ;
                endcase
            end
            reg_rdata_out <= reg_req_in.rd ? rdata_nxt : 8'h00;
        end
    end

    // extraneous pulse flag: sticky, cleared by reading it, a new event wins
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in)
            extra_r <= 1'b0;
        else if (extra_set)
            extra_r <= 1'b1;
        else if (reg_req_in.rd && reg_req_in.addr == `VSP_OFS_STATUS)
            extra_r <= 1'b0;
    end

    // ------------------------------------------------
    // input synchronisers
    // ------------------------------------------------
    logic [3:0] pin_s1_r, pin_s2_r;
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
        end else begin
            pin_s1_r <= pins_in;
            pin_s2_r <= pin_s1_r;
        end
    end

    logic hs_raw, vs_raw, green_raw, coast_raw;
    assign {hs_raw, vs_raw, green_raw, coast_raw} = pin_s2_r;

    // ------------------------------------------------
    // polarity detect: sync spends less time active than idle
    // ------------------------------------------------
    logic [LINE_W-1:0] pol_cnt_r;
    logic              pol_high, hs_act, comp_act;
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in)
            // start just on the active-high side: the flushed synchroniser
            // reads low, so no false leading edge follows reset
            pol_cnt_r <= {1'b0, {(LINE_W-1){1'b1}}};
        else if (hs_raw && pol_cnt_r != {LINE_W{1'b1}})
            pol_cnt_r <= pol_cnt_r + LINE_W'(1);
        else if (!hs_raw && pol_cnt_r != {LINE_W{1'b0}})
            pol_cnt_r <= pol_cnt_r - LINE_W'(1);
    end

    // override bit forces the input polarity, one meaning active high
    assign pol_high = opol_r[`VSP_BIT_POL_OVR] ? opol_r[`VSP_BIT_IN_POL]
                                               : !pol_cnt_r[LINE_W-1];
    assign hs_act   = pol_high ? hs_raw : !hs_raw;
    // slicer output is active low composite sync
    assign comp_act = coast_r[`VSP_BIT_SRC_GREEN] ? !green_raw : hs_act;

    // ------------------------------------------------
    // sync separator on a 6 MHz tick made by a fractional accumulator
    // ------------------------------------------------
    logic [4:0]               acc_r;
    logic                     tick;
    logic [7:0]               sep_cnt_r;
    video_sync_pkg::sep_state_e sep_st_r;
    logic                     sep_vs_r;
    logic [5:0]               acc_sum;

    assign acc_sum = {1'b0, acc_r} + {1'b0, `VSP_SEP_TICK_NUM};
    assign tick    = acc_sum >= {1'b0, `VSP_SEP_TICK_DEN};

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in)
            acc_r <= 5'h00;
        else
            acc_r <= tick ? 5'(acc_sum - {1'b0, `VSP_SEP_TICK_DEN}) : acc_sum[4:0];
    end

    // separator state machine, same for either sync polarity
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sep_st_r  <= video_sync_pkg::SEP_SEEK;
            sep_cnt_r <= 8'h00;
            sep_vs_r  <= 1'b0;
        end else if (tick) begin
            case (sep_st_r)
                video_sync_pkg::SEP_SEEK: begin
                    if (sep_cnt_r > thr_r) begin
                        sep_st_r  <= video_sync_pkg::SEP_VSYNC;
                        sep_vs_r  <= 1'b1;
                        sep_cnt_r <= 8'h00;
                    end else begin
                        sep_cnt_r <= sat_step(sep_cnt_r, comp_act);
                    end
                end
                video_sync_pkg::SEP_VSYNC: begin
                    if (comp_act) begin
                        sep_cnt_r <= 8'h00;
                    end else if (sep_cnt_r >= thr_r) begin
                        sep_st_r  <= video_sync_pkg::SEP_SEEK;
                        sep_vs_r  <= 1'b0;
                        sep_cnt_r <= 8'h00;
                    end else begin
                        sep_cnt_r <= sat_step(sep_cnt_r, 1'b1);
                    end
                end
                default: sep_st_r <= video_sync_pkg::SEP_SEEK;
            endcase
        end
    end

    // ------------------------------------------------
    // line sync regenerator and filter
    // ------------------------------------------------
    logic              hs_dly_r, lead;
    logic [LINE_W-1:0] ph_r, period_r, win, early_lim;
    logic              locked, in_early, in_late, in_win, regen_edge;
    logic              filt_r, regen_hs, seen_r;

    assign lead       = hs_act && !hs_dly_r;
    assign win        = win_cycles(window_r);
    assign locked     = period_r != {LINE_W{1'b0}};
    assign early_lim  = (period_r > win) ? period_r - win : {LINE_W{1'b0}};
    assign in_early   = ph_r >= early_lim;
    assign in_late    = ph_r <= win;
    assign in_win     = !locked || in_early || in_late;
    assign regen_edge = locked && ph_r == period_r;
    assign regen_hs   = locked && ph_r < LINE_W'(width_r);
    assign extra_set  = lead && !in_win;

    // no setup: the first edge starts timing and the second seeds the period,
    // since time since reset is no period; stray edges are ignored and
    // a missing edge is replaced by the predicted one
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hs_dly_r <= 1'b0;
            ph_r     <= {LINE_W{1'b0}};
            period_r <= {LINE_W{1'b0}};
            filt_r   <= 1'b0;
            seen_r   <= 1'b0;
        end else begin
            hs_dly_r <= hs_act;
            if (lead)
                seen_r <= 1'b1;
            if (lead && in_win) begin
                ph_r <= {LINE_W{1'b0}};
                if (locked ? in_early : seen_r)
                    period_r <= ph_r;
            end else if (regen_edge) begin
                ph_r <= {LINE_W{1'b0}};
            end else if (ph_r != {LINE_W{1'b1}}) begin
                ph_r <= ph_r + LINE_W'(1);
            end
            if (lead)
                filt_r <= in_win;
            else if (!hs_act)
                filt_r <= 1'b0;
        end
    end

    // ------------------------------------------------
    // source selection and coast
    // ------------------------------------------------
    logic proc_hs, pll_src, coast_act;
    assign proc_hs   = sel_r[`VSP_BIT_REGEN] ? regen_hs : hs_act;
    assign pll_src   = sel_r[`VSP_BIT_PLL_FILT] ? filt_r : hs_act;
    // external coast is the far side's business; tied inactive when unused
    assign coast_act = coast_r[`VSP_BIT_COAST_INT] ? sep_vs_r
                     : (coast_r[`VSP_BIT_COAST_POL] ? coast_raw : !coast_raw);

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pll_ref_out         <= 1'b0;
            coast_out           <= 1'b0;
            frame_sync_out      <= 1'b0;
            phase_step_out      <= 5'h00;
            slicer_level_out    <= 5'h00;
            vsync_filter_en_out <= 1'b0;
        end else begin
            pll_ref_out         <= pll_src && !coast_act;
            coast_out           <= coast_act;
            frame_sync_out      <= sep_vs_r;
            phase_step_out      <= phase_r[4:0];
            slicer_level_out    <= slicer_r[7:3];
            vsync_filter_en_out <= sel_r[`VSP_BIT_VS_FILT];
        end
    end

    // ------------------------------------------------
    // output data clock, pixel pipeline and line sync output
    // ------------------------------------------------
    logic       data_en, proc_dly_r, ls_pend_r;
    logic [7:0] ls_cnt_r;
    logic [4:0] sets_r;

    // data moves when the clock output falls, so its rise sits mid-data
    assign data_en = output_data_clock_out;

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            output_data_clock_out <= 1'b0;
            pixel_out             <= 8'h00;
            pixel_valid_out       <= 1'b0;
            sets_r                <= 5'h00;
            proc_dly_r            <= 1'b0;
            ls_pend_r             <= 1'b0;
            ls_cnt_r              <= 8'h00;
            line_sync_out         <= 1'b0;
        end else begin
            output_data_clock_out <= !output_data_clock_out;
            proc_dly_r            <= proc_hs;
            // leading edge is held until the next data set so it lines up
            if (data_en)
                ls_pend_r <= 1'b0;
            else if (proc_hs && !proc_dly_r)
                ls_pend_r <= 1'b1;
            if (data_en) begin
                pixel_out <= pixel_in;
                if (sets_r != `VSP_PIPE_SETS)
                    sets_r <= sets_r + 5'h01;
                pixel_valid_out <= sets_r == `VSP_PIPE_SETS;
                if (ls_pend_r || (proc_hs && !proc_dly_r))
                    ls_cnt_r <= width_r;
                else if (ls_cnt_r != 8'h00)
                    ls_cnt_r <= ls_cnt_r - 8'h01;
                // width counts data sets so edges stay on data changes
                line_sync_out <= (ls_pend_r || (proc_hs && !proc_dly_r) ? (width_r != 8'h00)
                                 : (ls_cnt_r > 8'h01)) == opol_r[`VSP_BIT_OUT_POL];
            end
        end
    end

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    a_dclk_toggle: assert property ($past(nrst_in) |-> output_data_clock_out != $past(output_data_clock_out))
        else $error("data clock did not toggle");
    a_data_mid: assert property ($changed(pixel_out) |-> !output_data_clock_out)
        else $error("pixel data changed on a data clock rise");
    a_valid_after: assert property ($rose(pixel_valid_out) |-> $past(sets_r) == `VSP_PIPE_SETS)
        else $error("valid data flagged before the pipeline flushed");
    a_coast_blocks: assert property (coast_act |=> !pll_ref_out)
        else $error("pll reference passed during coast");
    a_sep_detect: assert property (tick && sep_st_r == video_sync_pkg::SEP_SEEK && sep_cnt_r > thr_r
        |=> sep_vs_r && sep_cnt_r == 8'h00)
        else $error("vertical sync not declared over threshold");
    a_sep_release: assert property ($fell(sep_vs_r) |-> $past(sep_cnt_r) >= thr_r && sep_cnt_r == 8'h00)
        else $error("vertical sync released early");
    a_sep_floor: assert property (tick && sep_st_r == video_sync_pkg::SEP_SEEK && sep_cnt_r == 8'h00
        && !comp_act && thr_r != 8'hff |=> sep_cnt_r == 8'h00)
        else $error("separator counter underflowed");
    a_extra_flag: assert property (extra_set |=> extra_r)
        else $error("extraneous pulse not flagged");
    a_coast_out: assert property (coast_act |=> ##[0:1] coast_out)
        else $error("coast not reported");
endmodule : video_sync_processor

// ### common/video_sync_params.svh
`ifndef VIDEO_SYNC_PARAMS_SVH
`define VIDEO_SYNC_PARAMS_SVH
// register offsets
`define VSP_OFS_PHASE     8'h04
`define VSP_OFS_SEP_THR   8'h11
`define VSP_OFS_COAST     8'h12
`define VSP_OFS_STATUS    8'h16
`define VSP_OFS_SLICER    8'h1d
`define VSP_OFS_WINDOW    8'h20
`define VSP_OFS_SYNC_SEL  8'h21
`define VSP_OFS_OUT_WIDTH 8'h23
`define VSP_OFS_OUT_POL   8'h24
// field positions
`define VSP_BIT_COAST_POL 0
`define VSP_BIT_COAST_INT 1
`define VSP_BIT_SRC_GREEN 2
`define VSP_BIT_EXTRA     0
`define VSP_BIT_VS_FILT   5
`define VSP_BIT_PLL_FILT  6
`define VSP_BIT_REGEN     7
`define VSP_BIT_IN_POL    5
`define VSP_BIT_POL_OVR   6
`define VSP_BIT_OUT_POL   7
// reset values
`define VSP_RST_PHASE     8'h00
`define VSP_RST_SEP_THR   8'h20
`define VSP_RST_COAST     8'h00
`define VSP_RST_SLICER    8'h80
`define VSP_RST_WINDOW    8'h0a
`define VSP_RST_SYNC_SEL  8'h00
`define VSP_RST_OUT_WIDTH 8'h20
`define VSP_RST_OUT_POL   8'h80
// timing
`define VSP_CLK_NS        40
`define VSP_WIN_UNIT_NS   25
`define VSP_SEP_TICK_NUM  5'h06
`define VSP_SEP_TICK_DEN  5'h19
`define VSP_PIPE_SETS     5'h17
`endif

// ### common/video_sync_pkg.sv
package video_sync_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic green_sync;
        logic coast;
    } sync_pins_s;

    typedef enum logic {
        SEP_SEEK  = 1'b0,
        SEP_VSYNC = 1'b1
    } sep_state_e;
endpackage : video_sync_pkg

// ### sim/sync_source.sv
`timescale 1ns/1ps
// ----------------------------------------
// far-side sync source model
// ----------------------------------------
module sync_source (
    // clock
    input  wire logic                  clk_in,
    // scenario controls
    input  wire logic                  coast_in,
    input  wire logic                  extra_in,
    input  wire logic                  long_in,
    // sync pins toward the device
    output video_sync_pkg::sync_pins_s pins_out
);
    int unsigned pos = 0;
    logic        line_act;
    logic        comp_act;
    // 100-cycle lines with an 8-cycle pulse; a stray pulse sits mid-line when asked
    always @(posedge clk_in) pos <= (pos == 99) ? 0 : pos + 1;
    assign line_act = (pos < 8) || (extra_in && pos >= 50 && pos < 54);
    // frame pulses leave only 6-cycle serration gaps, too short to end a detected frame
    assign comp_act = long_in ? (pos < 94) : (pos < 8);
    assign pins_out.hsync      = line_act;
    assign pins_out.vsync      = long_in;
    assign pins_out.green_sync = ~comp_act;
    // coast stays low, inactive only with active-high coast polarity, unless a scenario drives it
    assign pins_out.coast      = coast_in;
endmodule : sync_source

// ### sim/video_sync_processor_tb_top.sv
`timescale 1ns/1ps
`include "video_sync_params.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); end end
module video_sync_processor_tb_top;
    logic                       core_clk_in = 1'b0;
    logic                       nrst_in     = 1'b0;
    video_sync_pkg::reg_req_s   req         = '0;
    video_sync_pkg::sync_pins_s pins;
    logic [7:0]                 pixel_in    = 8'h00;
    logic [7:0]                 rdata;
    logic [7:0]                 pixel_out;
    logic [4:0]                 phase;
    logic [4:0]                 slicer;
    logic                       valid, dclk, lsync, fsync, pll_ref, coast, vs_en;
    logic                       coast_req = 1'b0, extra_req = 1'b0, long_req = 1'b0;
    int                         n_mismatch = 0, compares = 0, cyc = 0;
    // ----------------------------------------
    // clock, pixel ramp, hang guard
    // ----------------------------------------
    always #20 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) pixel_in <= pixel_in + 8'h01;
    // whole run needs about 3300 cycles, so this only trips on a hang
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            conclude();
        end
    end
    sync_source src (.clk_in(core_clk_in), .coast_in(coast_req), .extra_in(extra_req),
                     .long_in(long_req), .pins_out(pins));
    video_sync_processor #(.LINE_W(12)) dut (
        .core_clk_in(core_clk_in), .nrst_in(nrst_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .pins_in(pins), .pixel_in(pixel_in), .pixel_out(pixel_out), .pixel_valid_out(valid),
        .output_data_clock_out(dclk), .line_sync_out(lsync), .frame_sync_out(fsync),
        .pll_ref_out(pll_ref), .coast_out(coast), .phase_step_out(phase),
        .slicer_level_out(slicer), .vsync_filter_en_out(vs_en));
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : tick
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge core_clk_in);
        req.wr    <= 1'b0;
    endtask : reg_wr
    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge core_clk_in);
        req.rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd
    // counts the cycles out of len in which the pll reference output is high
    task automatic count_ones(input int len, output int ones);
        ones = 0;
        repeat (len) begin
            tick(1);
            if (pll_ref === 1'b1) ones++;
        end
    endtask : count_ones
    task automatic measure(input logic lvl, output int w);
        int n;
        n = 0;
        while (lsync === lvl && n < 300) begin
            tick(1);
            n++;
        end
        while (lsync !== lvl && n < 600) begin
            tick(1);
            n++;
        end
        `CHK(dclk, 1'b0)
        w = 0;
        while (lsync === lvl && w < 300) begin
            tick(1);
            w++;
        end
    endtask : measure
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_data();
        int         sets;
        logic [7:0] last;
        logic       prev;
        sets = 0;
        last = pixel_out;
        prev = dclk;
        repeat (60) begin
            tick(1);
            `CHK(dclk, ~prev)
            if (pixel_out !== last) begin
                sets++;
                `CHK(dclk, 1'b0)
            end
            if (sets <= 23) `CHK(valid, 1'b0)
            if (sets >= 24) `CHK(valid, 1'b1)
            last = pixel_out;
            prev = dclk;
        end
        `CHK(sets >= 28, 1'b1)
    endtask : t_data
    task automatic t_regs();
        logic [7:0] d;
        logic [7:0] ofs [5] = '{`VSP_OFS_SEP_THR, `VSP_OFS_WINDOW, `VSP_OFS_OUT_WIDTH, `VSP_OFS_OUT_POL,
                                `VSP_OFS_SLICER};
        logic [7:0] rst [5] = '{8'h20, 8'h0a, 8'h20, 8'h80, 8'h80};
        for (int i = 0; i < 5; i++) begin
            reg_rd(ofs[i], d);
            `CHK(d, rst[i])
            // low three bits clear so the five-bit slicer field reads back whole
            reg_wr(ofs[i], 8'h38);
            reg_rd(ofs[i], d);
            `CHK(d, 8'h38)
            reg_wr(ofs[i], rst[i]);
        end
        // unmapped place reads zero; the status place ignores writes
        reg_wr(8'h30, 8'hff);
        reg_rd(8'h30, d);
        `CHK(d, 8'h00)
        reg_wr(`VSP_OFS_STATUS, 8'hff);
        reg_rd(`VSP_OFS_STATUS, d);
        `CHK(d[0], 1'b0)
    endtask : t_regs
    task automatic t_fields();
        reg_wr(`VSP_OFS_PHASE, 8'h1f);
        reg_wr(`VSP_OFS_SLICER, 8'ha8);
        reg_wr(`VSP_OFS_SYNC_SEL, 8'h20);
        tick(2);
        `CHK(phase, 5'h1f)
        `CHK(slicer, 5'h15)
        `CHK(vs_en, 1'b1)
    endtask : t_fields
    task automatic t_line();
        int w;
        reg_wr(`VSP_OFS_OUT_WIDTH, 8'h04);
        tick(400);
        measure(1'b1, w);
        `CHK(w, 8)
        reg_wr(`VSP_OFS_OUT_POL, 8'h00);
        tick(200);
        measure(1'b0, w);
        `CHK(w, 8)
    endtask : t_line
    task automatic t_coast();
        int n;
        reg_wr(`VSP_OFS_COAST, 8'h00);
        tick(6);
        `CHK(coast, 1'b1)
        reg_wr(`VSP_OFS_COAST, 8'h01);
        tick(6);
        `CHK(coast, 1'b0)
        @(posedge core_clk_in);
        coast_req <= 1'b1;
        tick(6);
        `CHK(coast, 1'b1)
        count_ones(250, n);
        `CHK(n, 0)
        @(posedge core_clk_in);
        coast_req <= 1'b0;
        tick(6);
        `CHK(coast, 1'b0)
        count_ones(200, n);
        `CHK(n > 0, 1'b1)
    endtask : t_coast
    task automatic t_sep();
        int n;
        reg_wr(`VSP_OFS_SEP_THR, 8'h03);
        reg_wr(`VSP_OFS_COAST, 8'h07);
        n = 0;
        repeat (300) begin
            tick(1);
            if (fsync === 1'b1) n++;
        end
        `CHK(n, 0)
        do tick(1); while (src.pos != 98);
        @(posedge core_clk_in);
        long_req <= 1'b1;
        n = 0;
        while (fsync !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        `CHK(n >= 13 && n <= 30, 1'b1)
        tick(3);
        `CHK(coast, 1'b1)
        n = 0;
        repeat (250) begin
            tick(1);
            if (fsync !== 1'b1) n++;
        end
        `CHK(n, 0)
        @(posedge core_clk_in);
        long_req <= 1'b0;
        n = 0;
        while (fsync !== 1'b0 && n < 300) begin
            tick(1);
            n++;
        end
        `CHK(fsync, 1'b0)
        reg_wr(`VSP_OFS_COAST, 8'h01);
    endtask : t_sep
    task automatic t_filter();
        logic [7:0] d;
        int         n_in, n_out, n_ls;
        reg_wr(`VSP_OFS_SYNC_SEL, 8'hc0);
        tick(800);
        reg_rd(`VSP_OFS_STATUS, d);
        tick(300);
        reg_rd(`VSP_OFS_STATUS, d);
        `CHK(d[0], 1'b0)
        @(posedge core_clk_in);
        extra_req <= 1'b1;
        n_in = 0;
        n_out = 0;
        n_ls = 0;
        repeat (200) begin
            tick(1);
            if (pll_ref === 1'b1 && src.pos < 14) n_in++;
            if (pll_ref === 1'b1 && src.pos >= 52 && src.pos <= 58) n_out++;
            // output is active low here; the regenerated sync ignores the stray
            if (lsync === 1'b0 && src.pos >= 52 && src.pos <= 66) n_ls++;
        end
        `CHK(n_out, 0)
        `CHK(n_in > 0, 1'b1)
        `CHK(n_ls, 0)
        @(posedge core_clk_in);
        extra_req <= 1'b0;
        // let a stray still in the synchroniser land before reading
        tick(8);
        reg_rd(`VSP_OFS_STATUS, d);
        `CHK(d[0], 1'b1)
        reg_rd(`VSP_OFS_STATUS, d);
        `CHK(d[0], 1'b0)
    endtask : t_filter
    task automatic conclude();
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (16) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        t_data();
        t_regs();
        t_fields();
        t_line();
        t_coast();
        t_sep();
        t_filter();
        conclude();
    end
endmodule : video_sync_processor_tb_top
